/* rtl/erxsw_top.sv */
// Rx extended status writeback, init control and PHY management
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "erxsw_cfg.svh"
module erxsw_top #(
    parameter int SWR_CYC = `ERXSW_SWR_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [12:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_rx_clk,
    input wire logic i_rx_valid,
    input wire erxsw_pkg::erxsw_rx_res_t i_rx_res,
    input wire logic i_bm_pending,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oen,
    output logic o_mdc,
    output erxsw_pkg::erxsw_wb_t o_wb,
    output logic o_rx_run,
    output logic o_tx_run,
    output logic o_mii_port,
    output logic o_speed100,
    output logic o_full_duplex
);
    function automatic logic [3:0] ptp_kind(input logic ptp,
        input logic [7:0] ctrl, input logic [3:0] typ);
        logic [3:0] k;
        k = 4'h0;
        if (ptp && ctrl >= 8'h05 && ctrl <= 8'h0F) begin
            k = 4'hF;
        end else if (ptp) begin
            case (typ)
                4'h0: k = 4'h1;
                4'h8: k = 4'h2;
                4'h1: k = 4'h3;
                4'h9: k = 4'h4;
                4'h2: k = 4'h5;
                4'h3: k = 4'h6;
                4'hA: k = 4'h7;
                4'hB: k = 4'h8;
                4'hD: k = 4'h9;
                4'hC: k = 4'hA;
                default: k = 4'h0;
            endcase
        end
        return k;
    endfunction : ptp_kind

    function automatic logic [2:0] pay_kind(input logic [7:0] proto,
        input logic skip);
        logic [2:0] k;
        k = 3'h0;
        if (!skip) begin
            case (proto)
                8'h11: k = 3'h1;
                8'h06: k = 3'h2;
                8'h01: k = 3'h3;
                default: k = 3'h0;
            endcase
        end
        return k;
    endfunction : pay_kind

    // Link clock and MDIO input synchronisers
    logic [2:0] rxc_s, next_rxc_s, mdi_s, next_mdi_s;
    logic rxc_lv, next_rxc_lv, mdi_lv, next_mdi_lv, rxc_rise;
    always_comb begin
        next_rxc_s = {rxc_s[1:0], i_rx_clk};
        next_mdi_s = {mdi_s[1:0], i_mdio};
        next_rxc_lv = (rxc_s[1] == rxc_s[2]) ? rxc_s[2] : rxc_lv;
        next_mdi_lv = (mdi_s[1] == mdi_s[2]) ? mdi_s[2] : mdi_lv;
        rxc_rise = next_rxc_lv && !rxc_lv;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rxc_s <= 3'h0;
            mdi_s <= 3'h7;
            rxc_lv <= 1'b0;
            mdi_lv <= 1'b1;
        end else begin
            rxc_s <= next_rxc_s;
            mdi_s <= next_mdi_s;
            rxc_lv <= next_rxc_lv;
            mdi_lv <= next_mdi_lv;
        end
    end

    // Control registers and receive writeback
    logic [31:0] mac_cfg, cfg_act, bus_mode, op_mode, rx_last;
    logic [31:0] next_mac_cfg, next_cfg_act, next_bus_mode, next_op_mode;
    logic [31:0] next_rx_last, next_rdata, w4;
    logic [1:0] cfg_lag, next_cfg_lag, ip_flags, next_ip;
    logic [3:0] swr_cnt, next_swr_cnt;
    logic normal_irq_summary, rxi, bm_q, next_nis, next_rxi, acc, swr_act, herr, perr;
    logic checksum_offload_enable, wr_cfg, wr_st, swr_go;
    logic [3:0] mk;
    erxsw_pkg::erxsw_wb_t next_wb;
    logic [15:0] mii_addr, mii_data;

    assign swr_act = swr_cnt != 4'h0;
    assign acc = i_rx_valid && o_rx_run && !swr_act;
    assign checksum_offload_enable = cfg_act[`ERXSW_B_IPC];
    assign wr_cfg = i_wr && !swr_act && i_addr == `ERXSW_A_MACCFG;
    assign wr_st = i_wr && !swr_act && i_addr == `ERXSW_A_STATUS;
    assign swr_go = i_wr && !swr_act && i_addr == `ERXSW_A_BUSMODE
        && i_wdata[`ERXSW_B_SWR];

    always_comb begin
        next_mac_cfg = mac_cfg;
        next_cfg_act = cfg_act;
        next_cfg_lag = cfg_lag;
        next_bus_mode = bus_mode;
        next_op_mode = op_mode;
        next_rx_last = rx_last;
        next_nis = normal_irq_summary;
        next_rxi = rxi;
        next_ip = ip_flags;
        next_swr_cnt = swr_cnt;
        next_wb = '0;
        w4 = 32'h0;
        mk = ptp_kind(i_rx_res.ptp, i_rx_res.ptp_ctrl, i_rx_res.ptp_type);
        herr = checksum_offload_enable && !i_rx_res.bypass && ((i_rx_res.ipv4
            && i_rx_res.hdr_calc != i_rx_res.hdr_rx)
            || i_rx_res.ver_mismatch);
        perr = checksum_offload_enable && !i_rx_res.bypass && !herr && !i_rx_res.frag
            && (i_rx_res.pl_calc != i_rx_res.pl_rx
            || i_rx_res.len_mismatch);
        if (swr_act) begin
            // Config, mode and receive status registers held in reset until the count runs out
            next_swr_cnt = swr_cnt - 4'h1;
            next_mac_cfg = `ERXSW_REG_RST;
            next_cfg_act = `ERXSW_REG_RST;
            next_cfg_lag = 2'h0;
            next_bus_mode = `ERXSW_REG_RST;
            next_op_mode = `ERXSW_REG_RST;
            next_rx_last = `ERXSW_REG_RST;
            next_nis = 1'b0;
            next_rxi = 1'b0;
            next_ip = 2'h0;
        end else begin
            // New MAC config settings reach the MAC only after two link clocks; mode register writes take effect at once
            if (cfg_lag != 2'h0 && rxc_rise) begin
                next_cfg_lag = cfg_lag - 2'h1;
                if (cfg_lag == 2'h1) begin
                    next_cfg_act = mac_cfg;
                end
            end
            if (wr_cfg) begin
                next_mac_cfg = i_wdata & `ERXSW_MACCFG_MASK;
                next_cfg_lag = `ERXSW_CFG_LAG;
            end
            if (i_wr && i_addr == `ERXSW_A_BUSMODE) begin
                next_bus_mode = i_wdata & `ERXSW_BUSMODE_MASK;
            end
            if (swr_go) begin
                next_swr_cnt = 4'(SWR_CYC);
            end
            if (i_wr && i_addr == `ERXSW_A_OPMODE) begin
                next_op_mode = i_wdata & `ERXSW_OPMODE_MASK;
            end
            if (wr_st && i_wdata[`ERXSW_B_NIS]) begin
                next_nis = 1'b0;
            end
            if (wr_st && i_wdata[`ERXSW_B_RXI]) begin
                next_rxi = 1'b0;
            end
            if (acc) begin
                if (checksum_offload_enable) begin
                    next_ip = {i_rx_res.ipv6, i_rx_res.ipv4};
                end
                w4[14] = i_rx_res.stamp_taken && i_rx_res.overflow;
                w4[13] = mk != 4'h0 && i_rx_res.v2;
                w4[12] = mk != 4'h0 && i_rx_res.over_eth;
                w4[11:8] = mk;
                w4[7:6] = next_ip;
                w4[5] = i_rx_res.bypass || !checksum_offload_enable;
                w4[4] = perr;
                w4[3] = herr;
                w4[2:0] = pay_kind(i_rx_res.proto, herr || i_rx_res.frag
                    || i_rx_res.bypass || !checksum_offload_enable);
                next_wb.we4 = 1'b1;
                next_wb.word4 = w4;
                next_wb.we67 = i_rx_res.last_desc;
                next_wb.word6 = i_rx_res.last_desc
                    ? i_rx_res.stamp[31:0] : 32'h0;
                next_wb.word7 = i_rx_res.last_desc
                    ? i_rx_res.stamp[63:32] : 32'h0;
                next_rx_last = w4;
                // Set after clear so a same-cycle event is kept
                next_rxi = 1'b1;
                next_nis = 1'b1;
            end
        end
        next_rdata = 32'h0;
        if (i_rd) begin
            case (i_addr)
                `ERXSW_A_MACCFG: next_rdata = mac_cfg;
                `ERXSW_A_MIIADR: next_rdata = {16'h0, mii_addr};
                `ERXSW_A_MIIDAT: next_rdata = {16'h0, mii_data};
                `ERXSW_A_BUSMODE: next_rdata = bus_mode
                    | {31'h0, swr_act};
                `ERXSW_A_STATUS: next_rdata = {15'h0, normal_irq_summary, 9'h0, rxi, 6'h0};
                `ERXSW_A_OPMODE: next_rdata = op_mode;
                `ERXSW_A_BUSST: next_rdata = {31'h0, bm_q};
                `ERXSW_A_RXST: next_rdata = rx_last;
                default: next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            mac_cfg <= `ERXSW_REG_RST;
            cfg_act <= `ERXSW_REG_RST;
            cfg_lag <= 2'h0;
            bus_mode <= `ERXSW_REG_RST;
            op_mode <= `ERXSW_REG_RST;
            rx_last <= `ERXSW_REG_RST;
            normal_irq_summary <= 1'b0;
            rxi <= 1'b0;
            ip_flags <= 2'h0;
            swr_cnt <= 4'h0;
            bm_q <= 1'b0;
            o_wb <= '0;
            o_rdata <= 32'h0;
            o_rx_run <= 1'b0;
            o_tx_run <= 1'b0;
            o_mii_port <= 1'b0;
            o_speed100 <= 1'b0;
            o_full_duplex <= 1'b0;
        end else begin
            mac_cfg <= next_mac_cfg;
            cfg_act <= next_cfg_act;
            cfg_lag <= next_cfg_lag;
            bus_mode <= next_bus_mode;
            op_mode <= next_op_mode;
            rx_last <= next_rx_last;
            normal_irq_summary <= next_nis;
            rxi <= next_rxi;
            ip_flags <= next_ip;
            swr_cnt <= next_swr_cnt;
            bm_q <= i_bm_pending;
            o_wb <= next_wb;
            o_rdata <= next_rdata;
            o_rx_run <= next_cfg_act[`ERXSW_B_RE]
                && next_op_mode[`ERXSW_B_SR];
            o_tx_run <= next_cfg_act[`ERXSW_B_TE]
                && next_op_mode[`ERXSW_B_ST];
            o_mii_port <= next_cfg_act[`ERXSW_B_PS];
            o_speed100 <= next_cfg_act[`ERXSW_B_SPD];
            o_full_duplex <= next_cfg_act[`ERXSW_B_DUP];
        end
    end

    // PHY management frame engine
    erxsw_pkg::erxsw_mii_st_t mii_st, next_mii_st;
    logic [15:0] next_mii_addr, next_mii_data;
    logic [31:0] mii_sh, next_mii_sh;
    logic [4:0] mii_cnt, next_mii_cnt;
    logic [2:0] mii_div, next_mii_div;
    logic next_mdc, next_oen, mii_go;
    assign mii_go = i_wr && !swr_act && i_addr == `ERXSW_A_MIIADR
        && i_wdata[`ERXSW_B_BUSY] && mii_st == erxsw_pkg::MII_IDLE;
    always_comb begin
        next_mii_st = mii_st;
        next_mii_addr = mii_addr;
        next_mii_data = mii_data;
        next_mii_sh = mii_sh;
        next_mii_cnt = mii_cnt;
        next_mii_div = mii_div;
        next_mdc = o_mdc;
        if (swr_act) begin
            next_mii_st = erxsw_pkg::MII_IDLE;
            next_mii_addr = 16'h0;
            next_mii_data = 16'h0;
            next_mdc = 1'b0;
        end else begin
            unique case (mii_st)
                erxsw_pkg::MII_IDLE: begin
                    if (i_wr && i_addr == `ERXSW_A_MIIDAT) begin
                        next_mii_data = i_wdata[15:0];
                    end
                    if (mii_go) begin
                        // Start, opcode, PHY, register, turnaround, data
                        next_mii_addr = i_wdata[15:0];
                        next_mii_sh = {2'h1,
                            i_wdata[`ERXSW_B_MIIWR] ? 2'h1 : 2'h2,
                            i_wdata[15:11], i_wdata[10:6], 2'h2,
                            mii_data};
                        next_mii_cnt = 5'h1F;
                        next_mii_div = 3'h0;
                        next_mii_st = erxsw_pkg::MII_RUN;
                    end
                end
                erxsw_pkg::MII_RUN: begin
                    next_mii_div = mii_div + 3'h1;
                    if (mii_div == 3'(`ERXSW_MDC_HALF - 1)) begin
                        next_mii_div = 3'h0;
                        next_mdc = !o_mdc;
                        if (o_mdc && !mii_addr[`ERXSW_B_MIIWR]
                            && mii_cnt < 5'h10) begin
                            // On the fall: pin sync lags a whole half period
                            next_mii_data = {mii_data[14:0], next_mdi_lv};
                        end
                        if (o_mdc && mii_cnt == 5'h0) begin
                            next_mii_addr[`ERXSW_B_BUSY] = 1'b0;
                            next_mii_st = erxsw_pkg::MII_IDLE;
                        end else if (o_mdc) begin
                            next_mii_cnt = mii_cnt - 5'h1;
                            next_mii_sh = {mii_sh[30:0], 1'b0};
                        end
                    end
                end
            endcase
        end
        // Released from turnaround on for reads
        next_oen = !(next_mii_st == erxsw_pkg::MII_RUN
            && (next_mii_addr[`ERXSW_B_MIIWR] || next_mii_cnt > 5'h11));
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            mii_st <= erxsw_pkg::MII_IDLE;
            mii_addr <= 16'h0;
            mii_data <= 16'h0;
            mii_sh <= 32'h0;
            mii_cnt <= 5'h0;
            mii_div <= 3'h0;
            o_mdc <= 1'b0;
            o_mdio <= 1'b1;
            o_mdio_oen <= 1'b1;
        end else begin
            mii_st <= next_mii_st;
            mii_addr <= next_mii_addr;
            mii_data <= next_mii_data;
            mii_sh <= next_mii_sh;
            mii_cnt <= next_mii_cnt;
            mii_div <= next_mii_div;
            o_mdc <= next_mdc;
            o_mdio <= next_oen ? 1'b1 : next_mii_sh[31];
            o_mdio_oen <= next_oen;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_ts_lost: assert property (acc |=> o_wb.word4[14]
        == $past(i_rx_res.stamp_taken && i_rx_res.overflow))
        else $error("timestamp lost flag wrong");
    a_ptp_ver: assert property (acc |=> o_wb.we4
        && (o_wb.word4[11:8] != 4'h0 || !o_wb.word4[13]))
        else $error("version bit without message kind");
    a_ptp_rsv: assert property (acc && i_rx_res.ptp
        && i_rx_res.ptp_ctrl inside {[8'h05:8'h0F]}
        |=> o_wb.word4[11:8] == 4'hF) else $error("reserved kind not 1111");
    a_ip_hold: assert property (acc && !checksum_offload_enable
        |=> o_wb.word4[7:6] == $past(ip_flags))
        else $error("ip seen flags changed with offload off");
    a_hdr_kind: assert property (o_wb.we4 && o_wb.word4[3]
        |-> o_wb.word4[2:0] == 3'h0) else $error("kind not forced on error");
    a_stamp_last: assert property (acc && !i_rx_res.last_desc
        |=> o_wb.we4 && !o_wb.we67) else $error("stamp on non-last descriptor");
    a_swr_clear: assert property (swr_go |=> swr_act[*8] ##1 !swr_act)
        else $error("soft reset length wrong");
    a_nis_w1c: assert property (wr_st && i_wdata[`ERXSW_B_NIS]
        && !acc |=> !normal_irq_summary) else $error("summary bit not cleared");
    a_rx_gate: assert property (i_rx_valid && !o_rx_run
        |=> !o_wb.we4) else $error("writeback while receive stopped");
    c_frame_last: cover property (acc && i_rx_res.last_desc ##1 o_wb.we67);
    c_soft_reset: cover property (swr_go ##9 !swr_act);
    c_mii_done: cover property (mii_go ##[1:300] mii_st == erxsw_pkg::MII_IDLE);
endmodule : erxsw_top

/* rtl/erxsw_cfg.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef ERXSW_CFG_SVH
`define ERXSW_CFG_SVH
`define ERXSW_A_MACCFG 13'h0000
`define ERXSW_A_MIIADR 13'h0010
`define ERXSW_A_MIIDAT 13'h0014
`define ERXSW_A_BUSMODE 13'h1000
`define ERXSW_A_STATUS 13'h1014
`define ERXSW_A_OPMODE 13'h1018
`define ERXSW_A_BUSST 13'h102C
`define ERXSW_A_RXST 13'h1040
`define ERXSW_B_PS 15
`define ERXSW_B_SPD 14
`define ERXSW_B_DUP 11
`define ERXSW_B_IPC 10
`define ERXSW_B_TE 3
`define ERXSW_B_RE 2
`define ERXSW_B_SWR 0
`define ERXSW_B_NIS 16
`define ERXSW_B_RXI 6
`define ERXSW_B_SR 1
`define ERXSW_B_ST 13
`define ERXSW_B_BUSY 0
`define ERXSW_B_MIIWR 1
`define ERXSW_MACCFG_MASK 32'h0000CC0C
`define ERXSW_BUSMODE_MASK 32'h06010000
`define ERXSW_OPMODE_MASK 32'h00002006
`define ERXSW_REG_RST 32'h00000000
`define ERXSW_CLK_NS 100
`define ERXSW_SWR_NS 800
`define ERXSW_SWR_CYC ((`ERXSW_SWR_NS + `ERXSW_CLK_NS - 1) / `ERXSW_CLK_NS)
`define ERXSW_MDC_NS 400
`define ERXSW_MDC_HALF ((`ERXSW_MDC_NS / 2 + `ERXSW_CLK_NS - 1) / `ERXSW_CLK_NS)
`define ERXSW_CFG_LAG 2'h2
`endif

/* rtl/erxsw_pkg.sv */
// Types shared by the receive status writeback block
package erxsw_pkg;
    typedef struct packed {
        logic ptp;
        logic v2;
        logic over_eth;
        logic [3:0] ptp_type;
        logic [7:0] ptp_ctrl;
        logic ipv4;
        logic ipv6;
        logic bypass;
        logic frag;
        logic ver_mismatch;
        logic len_mismatch;
        logic [15:0] hdr_calc;
        logic [15:0] hdr_rx;
        logic [15:0] pl_calc;
        logic [15:0] pl_rx;
        logic [7:0] proto;
        logic stamp_taken;
        logic overflow;
        logic last_desc;
        logic [63:0] stamp;
    } erxsw_rx_res_t;
    typedef struct packed {
        logic we4;
        logic we67;
        logic [31:0] word4;
        logic [31:0] word6;
        logic [31:0] word7;
    } erxsw_wb_t;
    typedef enum logic {MII_IDLE, MII_RUN} erxsw_mii_st_t;
endpackage : erxsw_pkg

/* verification/erxsw_phy_model.sv */
// PHY side model: free-running rx clock and MDIO responder
`timescale 1ns/1ps
module erxsw_phy_model #(
    parameter logic [15:0] RD_VAL = 16'hA5C3
) (
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_drv,
    output logic o_val,
    output logic o_rx_clk,
    output logic [31:0] o_frame
);
    int cnt = 32;
    logic rd_op = 1'b0;
    initial begin
        o_rx_clk = 1'b0;
        o_drv = 1'b0;
        o_val = 1'b1;
        o_frame = '0;
        // Odd offset keeps the link clock off the system clock edges
        #37;
        forever #400 o_rx_clk = ~o_rx_clk;
    end
    // Bits are taken from the wire, so the pull-up shows in turnaround
    always @(posedge i_mdc) begin
        if (cnt == 32) cnt = 0;
        o_frame = {o_frame[30:0], i_mdio};
        cnt = cnt + 1;
        if (cnt == 4) rd_op = o_frame[1:0] == 2'b10;
    end
    // Second turnaround bit, then data ahead of each rise; released after
    always @(negedge i_mdc) begin
        o_drv = rd_op && cnt >= 15 && cnt < 32;
        o_val = cnt < 16 ? 1'b0 : RD_VAL[(31 - cnt) & 15];
    end
endmodule : erxsw_phy_model

/* verification/erxsw_top_bench.sv */
// Self-checking bench for the rx status writeback block
`timescale 1ns/1ps
`include "erxsw_cfg.svh"
module erxsw_top_bench;
    localparam logic [63:0] KIND_MAP = 64'h009A_8742_0000_6531;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rx_valid = 1'b0;
    logic bm = 1'b1;
    logic checksum_offload_enable = 1'b1;
    logic [1:0] ipf = 2'h0;
    erxsw_pkg::erxsw_rx_res_t res = '0;
    erxsw_pkg::erxsw_wb_t wb;
    logic [31:0] rdata;
    logic [31:0] frame;
    logic rx_clk, mdio_o, mdio_oen, mdc, phy_drv, phy_val, mdio_w;
    logic rx_run, tx_run, mii_port, spd100, fdx;
    int num_errors = 0;
    int n_compared = 0;

    always #50 clk = ~clk;
    // Line is pulled up when neither end drives it
    assign mdio_w = !mdio_oen ? mdio_o : (phy_drv ? phy_val : 1'b1);

    erxsw_top u_erxsw_top (
        .i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_clk(rx_clk),
        .i_rx_valid(rx_valid), .i_rx_res(res), .i_bm_pending(bm),
        .i_mdio(mdio_w), .o_mdio(mdio_o), .o_mdio_oen(mdio_oen),
        .o_mdc(mdc), .o_wb(wb), .o_rx_run(rx_run), .o_tx_run(tx_run),
        .o_mii_port(mii_port), .o_speed100(spd100), .o_full_duplex(fdx)
    );
    erxsw_phy_model u_erxsw_phy_model (
        .i_mdc(mdc), .i_mdio(mdio_w), .o_drv(phy_drv), .o_val(phy_val),
        .o_rx_clk(rx_clk), .o_frame(frame)
    );

    task automatic finish_test;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_if(input logic ok);
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR t=%0t wait timed out", $time);
            finish_test();
        end
    endtask : stop_if

    task automatic wr_reg(input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [12:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic rchk(input logic [12:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask : rchk

    // Waits for the self-clearing bit 0 of a register
    task automatic poll(input logic [12:0] a, input int lim);
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < lim && d[0] !== 1'b0; i++) rd_reg(a, d);
        stop_if(d[0] === 1'b0);
    endtask : poll

    task automatic send(input erxsw_pkg::erxsw_rx_res_t r, input logic acc);
        logic [3:0] k;
        logic herr;
        logic perr;
        logic [2:0] pk;
        logic [31:0] w;
        k = r.ptp ? KIND_MAP[r.ptp_type * 4 +: 4] : 4'h0;
        if (r.ptp && r.ptp_ctrl >= 8'h05 && r.ptp_ctrl <= 8'h0F) k = 4'hF;
        if (checksum_offload_enable && acc) ipf = {r.ipv6, r.ipv4};
        herr = checksum_offload_enable & ~r.bypass
            & (r.ver_mismatch | (r.ipv4 & (r.hdr_calc != r.hdr_rx)));
        perr = checksum_offload_enable & ~r.bypass & ~herr & ~r.frag
            & (r.len_mismatch | (r.pl_calc != r.pl_rx));
        pk = r.proto == 8'h11 ? 3'h1 : r.proto == 8'h06 ? 3'h2
            : r.proto == 8'h01 ? 3'h3 : 3'h0;
        if (herr || r.frag || r.bypass || !checksum_offload_enable) pk = 3'h0;
        w = {17'h0, r.stamp_taken & r.overflow, r.v2 & (k != 4'h0),
            r.over_eth & (k != 4'h0), k, ipf, r.bypass | !checksum_offload_enable, perr, herr, pk};
        @(posedge clk);
        rx_valid <= 1'b1;
        res <= r;
        @(posedge clk);
        rx_valid <= 1'b0;
        #1;
        chk({31'h0, wb.we4}, {31'h0, acc});
        if (acc) begin
            chk(wb.word4, w);
            chk({31'h0, wb.we67}, {31'h0, r.last_desc});
        end
        if (acc && r.last_desc) begin
            chk(wb.word6, r.stamp[31:0]);
            chk(wb.word7, r.stamp[63:32]);
        end
    endtask : send

    initial begin
        #1000000;
        num_errors++;
        finish_test();
    end

    initial begin
        erxsw_pkg::erxsw_rx_res_t base;
        erxsw_pkg::erxsw_rx_res_t r;
        logic [12:0] regs [4] = '{`ERXSW_A_MACCFG, `ERXSW_A_BUSMODE,
            `ERXSW_A_OPMODE, `ERXSW_A_STATUS};
        logic [7:0] ctl [5] = '{8'h04, 8'h05, 8'h0F, 8'h10, 8'h07};
        int i;
        base = '0;
        base.ipv4 = 1'b1;
        base.proto = 8'h11;
        base.last_desc = 1'b1;
        base.stamp = 64'h0123_4567_89AB_CDEF;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rchk(`ERXSW_A_BUSST, 32'h1);
        @(posedge clk);
        bm <= 1'b0;
        rchk(`ERXSW_A_BUSST, 32'h0);
        foreach (regs[j]) rchk(regs[j], 32'h0);
        rchk(13'h0800, 32'h0);
        // Receiver stays off while its enable bit in the MAC config is clear
        wr_reg(`ERXSW_A_MACCFG, 32'hFFFF_FFFB);
        rchk(`ERXSW_A_MACCFG, 32'h0000_CC08);
        wr_reg(`ERXSW_A_BUSMODE, `ERXSW_BUSMODE_MASK);
        rchk(`ERXSW_A_BUSMODE, `ERXSW_BUSMODE_MASK);
        for (i = 0; i < 200 && mii_port !== 1'b1; i++) @(posedge clk);
        stop_if(mii_port);
        chk({29'h0, spd100, fdx, rx_run}, 32'h6);
        wr_reg(`ERXSW_A_OPMODE, `ERXSW_OPMODE_MASK);
        wr_reg(`ERXSW_A_MACCFG, 32'h0000_CC0C);
        for (i = 0; i < 200 && rx_run !== 1'b1; i++) @(posedge clk);
        stop_if(rx_run);
        chk({31'h0, tx_run}, 32'h1);
        for (i = 0; i < 16; i++) begin
            r = base;
            r.ptp = 1'b1;
            r.ptp_type = i[3:0];
            r.v2 = i[0];
            r.over_eth = i[1];
            send(r, 1'b1);
        end
        foreach (ctl[j]) begin
            r = base;
            r.ptp = j != 4;
            r.v2 = 1'b1;
            r.ptp_ctrl = ctl[j];
            send(r, 1'b1);
        end
        for (i = 0; i < 12; i++) begin
            r = base;
            r.stamp_taken = i >= 9;
            case (i)
                0: r.proto = 8'h06;
                1: r.proto = 8'h01;
                2: r.proto = 8'h02;
                3: r.hdr_rx = 16'h1234;
                4: r.ver_mismatch = 1'b1;
                5: r.pl_rx = 16'h0001;
                6: r.len_mismatch = 1'b1;
                7: r.frag = 1'b1;
                8: r.bypass = 1'b1;
                9: r.ipv6 = 1'b1;
                10: r.overflow = 1'b1;
                default: r.last_desc = 1'b0;
            endcase
            send(r, 1'b1);
        end
        rchk(`ERXSW_A_STATUS, 32'h0001_0040);
        wr_reg(`ERXSW_A_STATUS, 32'h0001_0000);
        rchk(`ERXSW_A_STATUS, 32'h0000_0040);
        wr_reg(`ERXSW_A_STATUS, 32'h0000_0040);
        rchk(`ERXSW_A_STATUS, 32'h0);
        wr_reg(`ERXSW_A_MACCFG, 32'h0000_C80C);
        checksum_offload_enable = 1'b0;
        // Offload setting reaches the MAC only after two rising link clock edges
        repeat (30) @(posedge clk);
        r = base;
        r.ipv4 = 1'b0;
        r.ipv6 = 1'b1;
        r.hdr_rx = 16'h1234;
        send(r, 1'b1);
        wr_reg(`ERXSW_A_MACCFG, 32'h0000_C808);
        for (i = 0; i < 200 && rx_run !== 1'b0; i++) @(posedge clk);
        stop_if(rx_run === 1'b0);
        chk({31'h0, tx_run}, 32'h1);
        send(base, 1'b0);
        wr_reg(`ERXSW_A_MIIDAT, 32'h0000_BEEF);
        wr_reg(`ERXSW_A_MIIADR, 32'h0000_9943);
        poll(`ERXSW_A_MIIADR, 200);
        chk(frame, {4'h5, 5'h13, 5'h05, 2'h2, 16'hBEEF});
        wr_reg(`ERXSW_A_MIIADR, 32'h0000_9941);
        poll(`ERXSW_A_MIIADR, 200);
        chk(frame, {4'h6, 5'h13, 5'h05, 2'h2, 16'hA5C3});
        rchk(`ERXSW_A_MIIDAT, 32'h0000_A5C3);
        wr_reg(`ERXSW_A_BUSMODE, 32'h0000_0001);
        wr_reg(`ERXSW_A_OPMODE, 32'h0000_2002);
        rchk(`ERXSW_A_BUSMODE, 32'h0000_0001);
        poll(`ERXSW_A_BUSMODE, 20);
        rchk(`ERXSW_A_MACCFG, 32'h0);
        rchk(`ERXSW_A_OPMODE, 32'h0);
        chk({30'h0, rx_run, tx_run}, 32'h0);
        finish_test();
    end
endmodule : erxsw_top_bench
